/* dv/csarb_bank_props.sv */
// checker for the bank register port and throttle output
// assumes it is bound into every csarb_bank instance
`timescale 1ns/1ps
`default_nettype none
module csarb_bank_props #(
  parameter [20:0] CNT_100US = 21'd12500
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [11:0] termination_target_o,
  input wire logic force_converter_off_o,
  input wire logic processor_throttle_output_n_o
);
  // ----
  // helpers
  // ----
  // low cycles are counted so the width check needs no long repetition
  logic [20:0] low_cnt_r;
  wire logic [15:0] rd = reg_rdata_o;
  wire logic [11:0] tg = termination_target_o;
  wire logic th = processor_throttle_output_n_o;
  wire logic [11:0] wv = reg_wdata_i[14:3];
  wire logic in_rng = wv >= 12'h271 && wv <= 12'h960;
  wire logic mapped = reg_addr_i == 8'h15 || reg_addr_i == 8'h30 ||
    (reg_addr_i >= 8'h20 && reg_addr_i <= 8'h26);
  always @(posedge clk_sys_i) begin
    if (!reset_n_i || th) begin
      low_cnt_r <= 21'h0;
    end else begin
      low_cnt_r <= low_cnt_r + 21'h1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_tw;
    reg_wr_i && reg_addr_i == 8'h15;
  endsequence
  property p_take;
    logic [11:0] v;
    (s_tw ##0 in_rng, v = wv) |=> tg == v;
  endproperty
  // ----
  // properties
  // ----
  a_target_take: assert property (p_take)
    else $error("accepted target not stored");
  a_target_refuse: assert property (s_tw ##0 !in_rng |=> $stable(tg))
    else $error("refused target changed the field");
  a_target_legal: assert property (tg != 12'h0 |->
    tg >= 12'h271 && tg <= 12'h960) else $error("target out of range");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(rd))
    else $error("read data moved without a read");
  a_target_readback: assert property (s_rd(8'h15) |=>
    rd == {1'b0, tg, 3'h0}) else $error("target readback wrong");
  a_force_bit: assert property (s_rd(8'h30) |=>
    !rd[2] && rd[3] == force_converter_off_o) else $error("option bits");
  a_unmapped_zero: assert property (reg_rd_i && !mapped |=> rd == 16'h0)
    else $error("unmapped read not zero");
  a_throttle_min: assert property ($rose(th) |->
    low_cnt_r >= CNT_100US) else $error("throttle pulse too short");
endmodule
bind csarb_bank csarb_bank_props #(.CNT_100US(CNT_100US))
  csarb_bank_props_i (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .termination_target_o(termination_target_o),
  .force_converter_off_o(force_converter_off_o),
  .processor_throttle_output_n_o(processor_throttle_output_n_o));
`default_nettype wire

/* dv/csarb_host_model.sv */
// host side of the register port: whole 16-bit word reads and writes
// assumes requests start only after reset has been released
`timescale 1ns/1ps
`default_nettype none
module csarb_host_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] rdata_i,
  output var logic [7:0] addr_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic [15:0] wdata_o
);
  initial begin
    addr_o = 8'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0;
  end
  // ----
  // transfers
  // ----
  // clearing writes of zero go through here; released data lines are inverted, the address is held
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* dv/test_charger_status_adc_register_bank.sv */
// self-checking bench for the charger status and result register bank
// assumes csarb_bank, the host model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module test_charger_status_adc_register_bank;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] lv = 12'h0;
  logic [18:0] ev = 19'h0;
  logic [7:0] vb = 8'h0, ib = 8'h0, cp = 8'h0, sy = 8'h0, bv = 8'h0;
  logic [6:0] ic = 7'h0, id = 7'h0, il = 7'h0;
  logic [7:0] addr;
  logic wr_s, rd_s, thr;
  logic [15:0] wdata, rdata;
  logic [11:0] tgt;
  wire [3:0] opt_o;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  csarb_host_model csarb_host_model_i (.clk_sys_i(clk), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr_s), .rd_o(rd_s), .wdata_o(wdata));
  // short counts keep the run brief: widths 4, 8, 12, 16 cycles
  csarb_bank #(.CNT_100US(21'd4), .CNT_1MS(21'd8), .CNT_5MS(21'd12),
    .CNT_10MS(21'd16)) csarb_bank_i (.clk_sys_i(clk), .reset_n_i(rst_n),
    .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .input_present_i(lv[11]),
    .adaptive_search_done_i(lv[10]), .assist_mode_active_i(lv[9]),
    .input_voltage_regulating_i(lv[8]), .input_current_regulating_i(lv[7]),
    .reverse_voltage_regulating_i(lv[6]), .reverse_current_limit_i(lv[5]),
    .fast_charge_active_i(lv[4]), .precharge_active_i(lv[3]),
    .reverse_supply_active_i(lv[2]), .overtemp_fault_i(lv[1]),
    .normal_operation_i(lv[0]), .fault_ev_i(ev[7:0]),
    .input_undervoltage_ev_i(ev[15]), .assist_exit_ev_i(ev[16]),
    .input_voltage_throttle_ev_i(ev[17]), .profile_ev_i(ev[14:8]),
    .effective_input_limit_i(il), .result_valid_i(ev[18]),
    .input_bus_voltage_i(vb), .charge_current_result_i(ic),
    .discharge_current_result_i(id), .input_current_result_i(ib),
    .comparator_pin_result_i(cp), .system_rail_result_i(sy),
    .battery_voltage_result_i(bv), .termination_target_o(tgt),
    .battery_shunt_select_o(opt_o[3]), .input_shunt_select_o(opt_o[2]),
    .force_converter_off_o(opt_o[1]),
    .input_voltage_profile_enable_o(opt_o[0]),
    .processor_throttle_output_n_o(thr));
  // ----
  // helpers
  // ----
  task give_verdict;
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    csarb_host_model_i.rd(a, d);
    chk(d, e);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    csarb_host_model_i.wr(a, d);
  endtask
  // events are held three cycles so the synchronisers see the edge
  task pulse(input logic [18:0] m);
    @(posedge clk) ev <= m;
    tick(3);
    ev <= 19'h0;
    tick(5);
  endtask
  task thr_is(input logic e);
    #1 chk({15'h0, thr}, {15'h0, e});
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    rc(8'h21, 16'hb800);
    rc(8'h30, 16'h3300);
    rc(8'h15, 16'h0000);
    rc(8'h40, 16'h0000);
    thr_is(1'b1);
    chk({12'h0, opt_o}, 16'h0000);
  endtask
  task t_target;
    wr(8'h15, 16'h1388);
    rc(8'h15, 16'h1388);
    wr(8'h15, 16'h4b08);
    wr(8'h15, 16'h1380);
    rc(8'h15, 16'h1388);
    wr(8'h15, 16'hcb07);
    rc(8'h15, 16'h4b00);
    chk({4'h0, tgt}, 16'h0960);
  endtask
  task t_live;
    @(posedge clk) lv <= 12'h064;
    tick(4);
    rc(8'h20, 16'h1900);
    @(posedge clk) lv <= 12'hffe;
    tick(4);
    rc(8'h20, 16'hff00);
    rc(8'h21, 16'hbc00);
    @(posedge clk) lv <= 12'h000;
    tick(4);
  endtask
  task t_faults;
    pulse(19'h000ff);
    rc(8'h20, 16'h00bb);
    rc(8'h20, 16'h0018);
    wr(8'h20, 16'h0000);
    rc(8'h20, 16'h0000);
    @(posedge clk) lv <= 12'h001;
    wr(8'h30, 16'h3308);
    pulse(19'h000ff);
    rc(8'h20, 16'h00ff);
    wr(8'h20, 16'h0000);
    rc(8'h20, 16'h0000);
  endtask
  task t_throttle;
    int n;
    n = 0;
    @(posedge clk) ev <= 19'h07f00;
    tick(3);
    ev <= 19'h0;
    repeat (40) begin
      @(posedge clk);
      #1 n += (thr === 1'b0);
    end
    chk({15'h0, n >= 16 && n <= 17}, 16'h0001);
    rc(8'h21, 16'hb87f);
    rc(8'h21, 16'hb800);
    wr(8'h21, 16'h4800);
    pulse(19'h00100);
    tick(20);
    thr_is(1'b0);
    wr(8'h21, 16'h4000);
    tick(3);
    thr_is(1'b1);
    rc(8'h21, 16'hc801);
    wr(8'h21, 16'h3800);
  endtask
  task t_assist;
    wr(8'h30, 16'hb308);
    #1 chk({12'h0, opt_o}, 16'h0003);
    pulse(19'h20000);
    tick(30);
    thr_is(1'b0);
    rc(8'h21, 16'hb880);
    wr(8'h21, 16'h3800);
    tick(4);
    thr_is(1'b1);
    pulse(19'h10000);
    rc(8'h21, 16'hb900);
    wr(8'h21, 16'h3800);
    rc(8'h21, 16'hb800);
    @(posedge clk) lv <= 12'h200;
    repeat (6) pulse(19'h08000);
    rc(8'h21, 16'hb800);
    pulse(19'h08000);
    rc(8'h21, 16'hbb00);
    wr(8'h21, 16'h3800);
    rc(8'h21, 16'hb800);
  endtask
  task t_adc;
    @(posedge clk) begin
      vb <= 8'ha5;
      ic <= 7'h5a;
      id <= 7'h33;
      ib <= 8'hc3;
      cp <= 8'h3c;
      sy <= 8'h96;
      bv <= 8'h69;
      il <= 7'h2c;
    end
    pulse(19'h40000);
    rc(8'h22, 16'h2c00);
    rc(8'h23, 16'ha500);
    rc(8'h24, 16'h5a33);
    rc(8'h25, 16'hc33c);
    rc(8'h26, 16'h9669);
    wr(8'h30, 16'h0c04);
    #1 chk({12'h0, opt_o}, 16'h000c);
    rc(8'h30, 16'h0c00);
  endtask
  initial begin
    tick(6);
    rst_n <= 1'b1;
    t_reset();
    t_target();
    t_live();
    t_faults();
    t_throttle();
    t_assist();
    t_adc();
    give_verdict();
  end
endmodule
`default_nettype wire

/* src/csarb_bank.v */
// charger status, throttle and converter result register bank
// assumes a byte-indexed register port driven by a serial bus front end on
// clk_sys_i; analog event inputs are asynchronous and are synchronised here
//
// Summary of operation
// - termination target 12 bits at 14:3
// - target write ignored outside 0x271..0x960
// - status upper byte shows live state
// - reverse regulation also sets regulating bits while reverse supply is active
// - listed faults latch and clear on read
// - system over/undervoltage clear by writing zero
// - discharge overcurrent only in normal operation
// - forced shutdown fault needs enable bit set
// - throttle extend enable bit, default off
// - throttle minimum width from two-bit field
// - writing zero to clear releases extension
// - overtemperature bit is live read-only
// - seven undervoltage events latch assist failure
// - assist exit causes latch exit flag
// - input-voltage profile holds throttle until cleared
// - profile trigger flags clear on read
// - effective input limit read-only at 14:8
// - input voltage result in upper byte
// - charge current result at 14:8
// - discharge current result at 6:0
// - input current result upper byte
// - comparator result lower byte
// - system and battery voltages share register
// - shunt select bits in option register
// - read-once-clear bits zero after read
`timescale 1ns/1ps
`default_nettype none
`include "csarb_regs.vh"
module csarb_bank #(
  parameter [20:0] CNT_100US = `CSARB_CLK_MHZ * `CSARB_W100US_US,
  parameter [20:0] CNT_1MS = `CSARB_CLK_MHZ * `CSARB_W1MS_US,
  parameter [20:0] CNT_5MS = `CSARB_CLK_MHZ * `CSARB_W5MS_US,
  parameter [20:0] CNT_10MS = `CSARB_CLK_MHZ * `CSARB_W10MS_US
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // live status levels (asynchronous)
  input wire input_present_i,
  input wire adaptive_search_done_i,
  input wire assist_mode_active_i,
  input wire input_voltage_regulating_i,
  input wire input_current_regulating_i,
  input wire reverse_voltage_regulating_i,
  input wire reverse_current_limit_i,
  input wire fast_charge_active_i,
  input wire precharge_active_i,
  input wire reverse_supply_active_i,
  input wire overtemp_fault_i,
  input wire normal_operation_i,
  // fault event levels (asynchronous, rising edge sets the flag)
  input wire [7:0] fault_ev_i,
  input wire input_undervoltage_ev_i,
  input wire assist_exit_ev_i,
  input wire input_voltage_throttle_ev_i,
  input wire [6:0] profile_ev_i,
  // analog side values
  input wire [6:0] effective_input_limit_i,
  input wire result_valid_i,
  input wire [7:0] input_bus_voltage_i,
  input wire [6:0] charge_current_result_i,
  input wire [6:0] discharge_current_result_i,
  input wire [7:0] input_current_result_i,
  input wire [7:0] comparator_pin_result_i,
  input wire [7:0] system_rail_result_i,
  input wire [7:0] battery_voltage_result_i,
  // control outputs
  output reg [11:0] termination_target_o,
  output wire battery_shunt_select_o,
  output wire input_shunt_select_o,
  output wire force_converter_off_o,
  output wire input_voltage_profile_enable_o,
  output reg processor_throttle_output_n_o
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam NSYNC = 38;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg [NSYNC-1:0] sync3_r;
  assign async_in = {input_present_i, adaptive_search_done_i,
    assist_mode_active_i, input_voltage_regulating_i,
    input_current_regulating_i, reverse_voltage_regulating_i,
    reverse_current_limit_i, fast_charge_active_i, precharge_active_i,
    reverse_supply_active_i, overtemp_fault_i, normal_operation_i,
    fault_ev_i, input_undervoltage_ev_i, assist_exit_ev_i,
    input_voltage_throttle_ev_i, profile_ev_i, result_valid_i,
    effective_input_limit_i};

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
      sync3_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire s_present = sync2_r[37];
  wire s_aicc = sync2_r[36];
  wire s_assist = sync2_r[35];
  wire s_vreg = sync2_r[34];
  wire s_ireg = sync2_r[33];
  wire s_rvreg = sync2_r[32];
  wire s_rilim = sync2_r[31];
  wire s_fast = sync2_r[30];
  wire s_pre = sync2_r[29];
  wire s_rev = sync2_r[28];
  wire s_otp = sync2_r[27];
  wire s_normal = sync2_r[26];
  // rising edges compare the second and third stages only
  wire [NSYNC-1:0] rise = sync2_r & ~sync3_r;
  wire [7:0] fault_rise = rise[25:18];
  wire uv_rise = rise[17];
  wire exit_rise = rise[16];
  wire mivr_rise = rise[15];
  wire [6:0] prof_rise = rise[14:8];
  wire valid_rise = rise[7];
  wire [6:0] s_ilim = sync2_r[6:0];
  // the limit word is taken only once two samples agree, so a skewed
  // change of its bits is never latched half-way
  wire ilim_steady = (sync2_r[6:0] == sync3_r[6:0]);

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire wr_term = reg_wr_i && (reg_addr_i == `CSARB_OFS_TERM_V);
  wire wr_stat = reg_wr_i && (reg_addr_i == `CSARB_OFS_STATUS);
  wire rd_stat = reg_rd_i && (reg_addr_i == `CSARB_OFS_STATUS);
  wire wr_thr = reg_wr_i && (reg_addr_i == `CSARB_OFS_THROT);
  wire rd_thr = reg_rd_i && (reg_addr_i == `CSARB_OFS_THROT);
  wire wr_opt = reg_wr_i && (reg_addr_i == `CSARB_OFS_OPT1);

  // ---------------------------------------------------------------
  // termination target and options
  // ---------------------------------------------------------------
  reg [15:0] opt1_r;
  wire [11:0] term_wval = reg_wdata_i[14:3];
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      termination_target_o <= `CSARB_RST_TERM_V;
      opt1_r <= `CSARB_RST_OPT1;
    end else begin
      if (wr_term && term_wval >= `CSARB_TERM_MIN &&
          term_wval <= `CSARB_TERM_MAX)
        termination_target_o <= term_wval;
      if (wr_opt)
        opt1_r <= reg_wdata_i & `CSARB_OPT1_RW_MASK;
    end
  end
  assign battery_shunt_select_o = opt1_r[`CSARB_BIT_BAT_SHUNT];
  assign input_shunt_select_o = opt1_r[`CSARB_BIT_IN_SHUNT];
  assign force_converter_off_o = opt1_r[`CSARB_BIT_FORCE_OFF];
  // ---------------------------------------------------------------
  // charger status faults
  // ---------------------------------------------------------------
  // fault_ev_i order: 7 in ov, 6 dis oc, 5 in oc, 4 sys ov, 3 sys uv,
  // 2 forced off, 1 rev ov, 0 rev uv
  reg [7:0] fault_r;
  reg [7:0] fault_set;
  reg [7:0] fault_nxt;
  always @* begin
    fault_set = fault_rise;
    fault_set[6] = fault_rise[6] & s_normal;
    fault_set[2] = fault_rise[2] &
      opt1_r[`CSARB_BIT_FORCE_OFF];
    fault_nxt = fault_r;
    if (rd_stat)
      fault_nxt = fault_nxt & 8'h18;
    if (wr_stat)
      fault_nxt[4:3] = fault_nxt[4:3] & reg_wdata_i[4:3];
    fault_nxt = fault_nxt | fault_set;
  end
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      fault_r <= 8'h00;
    else
      fault_r <= fault_nxt;
  end

  wire [7:0] live_stat = {s_present, s_aicc, s_assist,
    s_vreg | (s_rev & s_rvreg), s_ireg | (s_rev & s_rilim),
    s_fast, s_pre, s_rev};

  // ---------------------------------------------------------------
  // throttle status and control
  // ---------------------------------------------------------------
  reg ext_en_r;
  reg [1:0] width_r;
  reg clr_r;
  reg fail_r;
  reg exit_r;
  reg mivr_r;
  reg [6:0] prof_r;
  reg [6:0] prof_nxt;
  reg [2:0] uv_cnt_r;
  reg ext_hold_r;
  reg mivr_en_r;
  wire any_trig = (|prof_rise) | mivr_rise | exit_rise;
  wire uv_seventh = uv_rise && (uv_cnt_r == `CSARB_UV_EXIT_COUNT - 3'h1);
  wire timer_busy;

  always @* begin
    prof_nxt = prof_r;
    if (rd_thr)
      prof_nxt = 7'h00;
    prof_nxt = prof_nxt | prof_rise;
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ext_en_r <= `CSARB_RST_EXT_EN;
      width_r <= `CSARB_RST_WIDTH;
      clr_r <= `CSARB_RST_CLR;
      fail_r <= 1'b0;
      exit_r <= 1'b0;
      mivr_r <= 1'b0;
      prof_r <= 7'h00;
      uv_cnt_r <= 3'h0;
      ext_hold_r <= 1'b0;
      mivr_en_r <= 1'b0;
    end else begin
      prof_r <= prof_nxt;
      if (wr_thr) begin
        ext_en_r <= reg_wdata_i[`CSARB_BIT_EXT_EN];
        width_r <= reg_wdata_i[13:12];
        clr_r <= reg_wdata_i[`CSARB_BIT_CLR];
      end else if (!clr_r)
        clr_r <= 1'b1; // clear is a one-shot, back to idle
      // consecutive count restarts whenever assist mode is left
      if (!s_assist)
        uv_cnt_r <= 3'h0;
      else if (uv_rise)
        uv_cnt_r <= uv_seventh ? 3'h0 : uv_cnt_r + 3'h1;
      if (wr_thr && !reg_wdata_i[`CSARB_BIT_FAIL])
        fail_r <= 1'b0;
      if (wr_thr && !reg_wdata_i[`CSARB_BIT_EXIT])
        exit_r <= 1'b0;
      if (wr_thr && !reg_wdata_i[`CSARB_BIT_MIVR])
        mivr_r <= 1'b0;
      if (uv_seventh && s_assist) begin
        fail_r <= 1'b1;
        exit_r <= 1'b1;
      end
      if (exit_rise)
        exit_r <= 1'b1;
      if (mivr_rise && mivr_en_r)
        mivr_r <= 1'b1;
      // extension holds after the timer until the host clears it
      if (any_trig && ext_en_r)
        ext_hold_r <= 1'b1;
      else if (!clr_r)
        ext_hold_r <= 1'b0;
      mivr_en_r <= input_voltage_profile_enable_o;
    end
  end

  csarb_pulse_timer #(
    .CNT_100US(CNT_100US),
    .CNT_1MS(CNT_1MS),
    .CNT_5MS(CNT_5MS),
    .CNT_10MS(CNT_10MS)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(any_trig),
    .width_sel_i(width_r),
    .busy_o(timer_busy)
  );

  // profile enable for the input-voltage trigger is held in option bit 15
  assign input_voltage_profile_enable_o = opt1_r[15];

  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      processor_throttle_output_n_o <= 1'b1;
    else
      processor_throttle_output_n_o <= ~(timer_busy | ext_hold_r |
        mivr_r);
  end

  // ---------------------------------------------------------------
  // conversion results, captured whole on a valid edge; input limit once two samples agree
  // ---------------------------------------------------------------
  // result buses are sampled only on the synchronised valid edge, so the
  // analog side must hold them steady around that edge
  reg [7:0] vbus_r;
  reg [6:0] ichg_r;
  reg [6:0] idis_r;
  reg [7:0] input_current_result_r;
  reg [7:0] vcmp_r;
  reg [7:0] system_rail_result_r;
  reg [7:0] vbat_r;
  reg [6:0] ilim_r;
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      vbus_r <= 8'h00;
      ichg_r <= 7'h00;
      idis_r <= 7'h00;
      input_current_result_r <= 8'h00;
      vcmp_r <= 8'h00;
      system_rail_result_r <= 8'h00;
      vbat_r <= 8'h00;
      ilim_r <= `CSARB_RST_ILIM;
    end else begin
      if (ilim_steady)
        ilim_r <= s_ilim;
      if (valid_rise) begin
        vbus_r <= input_bus_voltage_i;
        ichg_r <= charge_current_result_i;
        idis_r <= discharge_current_result_i;
        input_current_result_r <= input_current_result_i;
        vcmp_r <= comparator_pin_result_i;
        system_rail_result_r <= system_rail_result_i;
        vbat_r <= battery_voltage_result_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        `CSARB_OFS_TERM_V: reg_rdata_o <= {1'b0, termination_target_o, 3'b000};
        `CSARB_OFS_STATUS: reg_rdata_o <= {live_stat, fault_r};
        `CSARB_OFS_THROT: reg_rdata_o <= {1'b1, ext_en_r, width_r, clr_r,
          s_otp, fail_r, exit_r, mivr_r, prof_r};
        `CSARB_OFS_ILIM: reg_rdata_o <= {1'b0, ilim_r, 8'h00};
        `CSARB_OFS_VBUS: reg_rdata_o <= {vbus_r, 8'h00};
        `CSARB_OFS_IBAT: reg_rdata_o <= {1'b0, ichg_r, 1'b0, idis_r};
        `CSARB_OFS_IINCMP: reg_rdata_o <= {input_current_result_r, vcmp_r};
        `CSARB_OFS_VSYSBAT: reg_rdata_o <= {system_rail_result_r, vbat_r};
        `CSARB_OFS_OPT1: reg_rdata_o <= opt1_r;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* src/csarb_pulse_timer.v */
// minimum-width timer for the processor throttle output
// assumes start is a one-cycle pulse on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module csarb_pulse_timer #(
  parameter [20:0] CNT_100US = 21'd12500,
  parameter [20:0] CNT_1MS = 21'd125000,
  parameter [20:0] CNT_5MS = 21'd625000,
  parameter [20:0] CNT_10MS = 21'd1250000
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire start_i,
  input wire [1:0] width_sel_i,
  output wire busy_o
);
  reg [20:0] cnt_r;
  reg [20:0] load_val;

  always @* begin
    case (width_sel_i)
      2'b00: load_val = CNT_100US;
      2'b01: load_val = CNT_1MS;
      2'b10: load_val = CNT_5MS;
      default: load_val = CNT_10MS;
    endcase
  end

  // a new trigger restarts the full width
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      cnt_r <= 21'h00000;
    else if (start_i)
      cnt_r <= load_val;
    else if (cnt_r != 21'h00000)
      cnt_r <= cnt_r - 21'h00001;
  end

  assign busy_o = (cnt_r != 21'h00000);
endmodule
`default_nettype wire

/* src/csarb_regs.vh */
// register map constants for the charger status and converter result bank
// assumes byte-wide register indices as seen on the serial management side
`ifndef CSARB_REGS_VH
`define CSARB_REGS_VH
`define CSARB_OFS_TERM_V 8'h15
`define CSARB_OFS_STATUS 8'h20
`define CSARB_OFS_THROT 8'h21
`define CSARB_OFS_ILIM 8'h22
`define CSARB_OFS_VBUS 8'h23
`define CSARB_OFS_IBAT 8'h24
`define CSARB_OFS_IINCMP 8'h25
`define CSARB_OFS_VSYSBAT 8'h26
`define CSARB_OFS_OPT1 8'h30
`define CSARB_RST_TERM_V 12'h000
`define CSARB_RST_THROT 16'hb800
`define CSARB_RST_OPT1 16'h3300
`define CSARB_RST_EXT_EN 1'h0
`define CSARB_RST_WIDTH 2'h3
`define CSARB_RST_CLR 1'h1
`define CSARB_RST_ILIM 7'h41
`define CSARB_TERM_MIN 12'h271
`define CSARB_TERM_MAX 12'h960
`define CSARB_OPT1_RW_MASK 16'hfffb
`define CSARB_BIT_FORCE_OFF 3
`define CSARB_BIT_BAT_SHUNT 10
`define CSARB_BIT_IN_SHUNT 11
`define CSARB_BIT_EXT_EN 14
`define CSARB_BIT_CLR 11
`define CSARB_BIT_FAIL 9
`define CSARB_BIT_EXIT 8
`define CSARB_BIT_MIVR 7
`define CSARB_CLK_MHZ 21'h7d
`define CSARB_W100US_US 21'h64
`define CSARB_W1MS_US 21'h3e8
`define CSARB_W5MS_US 21'h1388
`define CSARB_W10MS_US 21'h2710
`define CSARB_UV_EXIT_COUNT 3'h7
`endif
